//--- hdl/mit_core_timing.sv
// instruction timing unit: accepts opcodes, holds each for its cycle count
//
// What this block does
// - logic ops into accumulator: register 1B/1c, direct/immediate 2B/2c, indirect 1B/2c.
// - logic ops into a direct byte take 3 cycles; 2 or 3 bytes.
// - zero, invert, rotates and nibble trade on accumulator: 1 byte, 1 cycle.
// - external transfers only between accumulator and external space, indirect only.
// - code reads only read program memory, using indexed addressing.
// - 128 bit-addressable RAM bits plus bit-addressable special function registers.
// - accumulator loads: register 1c, indirect 2c, direct or immediate 2c.
// - working register loads: accumulator 1c, direct 3c, immediate 2c.
// - direct byte writes: accumulator/register 2c, indirect 3c, direct/immediate 3B/3c.
// - indirect RAM writes: accumulator 2c, direct 3c, immediate 2c.
// - data pointer constant load: 3 bytes, 3 cycles.
// - code read: 5 cycles via data pointer, 4 cycles via program counter.
// - external reads 4c/3c, writes 5c/4c for 8/16-bit address; 1 byte.
// - stack push 3 cycles, pop 2 cycles, both 2 bytes.
// - accumulator trade: register 2c, direct/indirect 3c, low digit trade 3c.
// - carry zero/one/invert 1B/1c; direct bit versions 2B/3c.
// - bit logic into carry 2B/2c; bit to carry 2c, carry to bit 3c.
// - carry branches 2B/3c; bit branches 3B/5c; set-and-clear form clears bit.
// - jumps: absolute/short 3c, long 4c, indexed 1B/5c.
// - calls 4 cycles, 2 or 3 bytes; both exits 1 byte, 4 cycles.
// - compare-branch 3 bytes: direct or indirect 5c, accumulator/register immediate 4c.
// - count-down branch: register 2B/4c, direct 3B/5c; accumulator tests 4c.
// - full compatibility with the standard 8-bit instruction set, one opcode held at a time with no overlap.
`timescale 1ns/1ps
`include "mit_cfg.svh"

module mit_core_timing
    import mit_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] op_bit_addr,
    output logic op_ready,
    output logic instr_retire,
    output logic [1:0] instr_len,
    output logic [2:0] instr_cycles,
    output mit_cls_e instr_class,
    output logic xdata_rd,
    output logic xdata_wr,
    output logic xdata_wide,
    output logic code_rd,
    output logic code_base_pc,
    output logic bit_valid,
    output logic [7:0] bit_byte_addr,
    output logic [2:0] bit_pos,
    output logic bit_in_func_reg,
    output logic bit_clear
);

    ////////////////////////////////////////////////////////////////////////////////

    mit_state_s st;
    mit_state_s next_st;
    logic accept;
    logic [1:0] dec_len;
    logic [2:0] dec_cycles;
    mit_cls_e dec_cls;
    logic dec_bit;
    logic dec_wide;
    logic dec_pc;

    // whole opcode map decoded, so any standard program runs with exact timing
    mit_op_decode u_dec (
        .opcode(op_byte),
        .len(dec_len),
        .cycles(dec_cycles),
        .cls(dec_cls),
        .bit_op(dec_bit),
        .xdata_wide(dec_wide),
        .code_from_pc(dec_pc)
    );

    // bit space: low half is RAM bytes from the base, high half is every
    // eighth special function register address
    function automatic logic [7:0] bit_to_byte(input logic [7:0] baddr);
        if (baddr < `MIT_BIT_RAM_BITS)
            return `MIT_BIT_RAM_BASE + {4'h0, baddr[6:3]};
        else
            return {baddr[7:3], 3'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    assign accept = op_valid && st.ready;

    always_comb
    begin
        next_st = st;
        next_st.retire = 1'b0;
        if (accept)
        begin
            next_st.len = dec_len;
            next_st.cycles = dec_cycles;
            next_st.cls = dec_cls;
            next_st.left = dec_cycles - 3'h1;
            next_st.ready = (dec_cycles == 3'h1);
            next_st.retire = (dec_cycles == 3'h1);
            // external space only through indirect pointers, read into or written from the accumulator
            next_st.xrd = (dec_cls == CLS_XDATA_RD);
            next_st.xwr = (dec_cls == CLS_XDATA_WR);
            next_st.xwide = dec_wide;
            next_st.code_rd = (dec_cls == CLS_CODE_RD);
            next_st.code_pc = dec_pc;
            next_st.bit_valid = dec_bit;
            next_st.bit_byte = bit_to_byte(op_bit_addr);
            next_st.bit_pos = op_bit_addr[2:0];
            next_st.bit_func_reg = op_bit_addr[7];
            next_st.bit_clear = (op_byte == `MIT_OPC_BIT_SET_CLEAR);
        end
        else if (st.left != 3'h0)
        begin
            // counting down one clock per cycle, no extra wait states
            next_st.left = st.left - 3'h1;
            next_st.ready = (st.left == 3'h1);
            next_st.retire = (st.left == 3'h1);
        end
        else
        begin
            // idle: drop strobes so memories see no stale access
            next_st.xrd = 1'b0;
            next_st.xwr = 1'b0;
            next_st.code_rd = 1'b0;
            next_st.bit_valid = 1'b0;
            next_st.bit_clear = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.ready <= `MIT_RST_READY;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign op_ready = st.ready;
    assign instr_retire = st.retire;
    assign instr_len = st.len;
    assign instr_cycles = st.cycles;
    assign instr_class = st.cls;
    assign xdata_rd = st.xrd;
    assign xdata_wr = st.xwr;
    assign xdata_wide = st.xwide;
    assign code_rd = st.code_rd;
    assign code_base_pc = st.code_pc;
    assign bit_valid = st.bit_valid;
    assign bit_byte_addr = st.bit_byte;
    assign bit_pos = st.bit_pos;
    assign bit_in_func_reg = st.bit_func_reg;
    assign bit_clear = st.bit_clear;

    ////////////////////////////////////////////////////////////////////////////////

    logic [3:0] bit_row;
    assign bit_row = op_bit_addr[6:3];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_logic_reg;
        accept && dec_cls == CLS_LOGIC && op_byte[3] |=> op_ready && instr_len == 2'h1;
    endproperty
    a_logic_reg: assert property (p_logic_reg)
        else $error("register logic op not one byte one cycle");

    property p_logic_dir;
        accept && dec_cls == CLS_LOGIC && op_byte[3:1] == 3'h1
            |=> !op_ready [*2] ##1 op_ready;
    endproperty
    a_logic_dir: assert property (p_logic_dir)
        else $error("logic op into direct byte not three cycles");

    property p_acc_single;
        accept && dec_cls == CLS_ACC1 |=> op_ready && instr_retire && instr_len == 2'h1;
    endproperty
    a_acc_single: assert property (p_acc_single)
        else $error("accumulator single operand op not one cycle");

    property p_xdata_only;
        (xdata_rd || xdata_wr) |-> !code_rd && !bit_valid && instr_len == 2'h1
            && (instr_class == CLS_XDATA_RD || instr_class == CLS_XDATA_WR);
    endproperty
    a_xdata_only: assert property (p_xdata_only)
        else $error("external access outside accumulator indirect transfer");

    property p_code_only;
        code_rd |-> !xdata_rd && !xdata_wr && instr_class == CLS_CODE_RD;
    endproperty
    a_code_only: assert property (p_code_only)
        else $error("code read touched external data space");

    property p_bit_ram;
        accept && dec_bit && op_bit_addr < `MIT_BIT_RAM_BITS
            |=> bit_valid && !bit_in_func_reg
            && bit_byte_addr == `MIT_BIT_RAM_BASE + {4'h0, $past(bit_row)};
    endproperty
    a_bit_ram: assert property (p_bit_ram)
        else $error("bit RAM address mapped to wrong byte");

    property p_ptr_load;
        accept && op_byte == `MIT_OPC_PTR_LOAD
            |=> !op_ready ##1 !op_ready ##1 op_ready && instr_len == 2'h3;
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("data pointer load not three cycles");

    property p_code_ptr;
        accept && op_byte == `MIT_OPC_CODE_PTR
            |=> code_rd && !code_base_pc ##0 !op_ready [*4] ##1 op_ready;
    endproperty
    a_code_ptr: assert property (p_code_ptr)
        else $error("code read via data pointer not five cycles");

    property p_code_pc;
        accept && op_byte == `MIT_OPC_CODE_PC
            |=> code_rd && code_base_pc ##0 !op_ready [*3] ##1 op_ready;
    endproperty
    a_code_pc: assert property (p_code_pc)
        else $error("code read via program counter not four cycles");

    property p_xrd_wide;
        accept && op_byte == `MIT_OPC_XRD_WIDE
            |=> xdata_rd && xdata_wide ##0 !op_ready [*2] ##1 op_ready;
    endproperty
    a_xrd_wide: assert property (p_xrd_wide)
        else $error("wide external read not three cycles");

    property p_set_clear;
        accept && op_byte == `MIT_OPC_BIT_SET_CLEAR
            |=> bit_clear && bit_valid && instr_cycles == 3'h5;
    endproperty
    a_set_clear: assert property (p_set_clear)
        else $error("set-and-clear branch lost its clear");

    property p_cmp_dir;
        accept && op_byte == `MIT_OPC_CMP_DIR |=> !op_ready [*4] ##1 op_ready;
    endproperty
    a_cmp_dir: assert property (p_cmp_dir)
        else $error("compare branch on direct byte not five cycles");

    property p_retire_ready;
        instr_retire |-> op_ready;
    endproperty
    a_retire_ready: assert property (p_retire_ready)
        else $error("retire without ready");

    property p_ready_rise;
        $rose(op_ready) |-> instr_retire && $past(st.left) == 3'h1;
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready rose before count elapsed");

    property p_xrd_narrow;
        accept && dec_cls == CLS_XDATA_RD && !dec_wide
            |=> xdata_rd && !xdata_wide ##0 !op_ready [*3] ##1 op_ready;
    endproperty
    a_xrd_narrow: assert property (p_xrd_narrow)
        else $error("narrow external read not four cycles");

    property p_xwr_narrow;
        accept && dec_cls == CLS_XDATA_WR && !dec_wide
            |=> xdata_wr && !xdata_wide ##0 !op_ready [*4] ##1 op_ready;
    endproperty
    a_xwr_narrow: assert property (p_xwr_narrow)
        else $error("narrow external write not five cycles");

    property p_stack_push;
        accept && op_byte == 8'hC0 |=> !op_ready [*2] ##1 op_ready && instr_len == 2'h2;
    endproperty
    a_stack_push: assert property (p_stack_push)
        else $error("stack push not two bytes three cycles");

    property p_stack_pop;
        accept && op_byte == 8'hD0 |=> !op_ready ##1 op_ready && instr_len == 2'h2;
    endproperty
    a_stack_pop: assert property (p_stack_pop)
        else $error("stack pop not two bytes two cycles");

    property p_carry_bit;
        accept && (op_byte == 8'hB3 || op_byte == 8'hC3 || op_byte == 8'hD3)
            |=> op_ready && instr_retire && instr_len == 2'h1 && !bit_valid;
    endproperty
    a_carry_bit: assert property (p_carry_bit)
        else $error("carry op not one byte one cycle");

    property p_indexed_jump;
        accept && op_byte == 8'h73 |=> instr_len == 2'h1 ##0 !op_ready [*4] ##1 op_ready;
    endproperty
    a_indexed_jump: assert property (p_indexed_jump)
        else $error("indexed jump not one byte five cycles");

    // both exits share the timing, so one property guards the pair
    property p_exit;
        accept && (op_byte == 8'h22 || op_byte == 8'h32)
            |=> instr_len == 2'h1 ##0 !op_ready [*3] ##1 op_ready;
    endproperty
    a_exit: assert property (p_exit)
        else $error("subroutine or interrupt exit not four cycles");

endmodule

//--- inc/mit_cfg.svh
// constants for the instruction timing unit: fixed codes, bit map, reset values
`ifndef MIT_CFG_SVH
`define MIT_CFG_SVH

`define MIT_RST_READY 1'b1
`define MIT_BIT_RAM_BASE 8'h20
`define MIT_BIT_RAM_BITS 8'h80
`define MIT_OPC_BIT_SET_CLEAR 8'h10
`define MIT_OPC_CODE_PC 8'h83
`define MIT_OPC_CODE_PTR 8'h93
`define MIT_OPC_PTR_LOAD 8'h90
`define MIT_OPC_CMP_DIR 8'hB5
`define MIT_OPC_XRD_WIDE 8'hE0
`define MIT_OPC_XWR_WIDE 8'hF0

`endif

//--- inc/mit_pkg.sv
// types shared by the instruction timing unit and its opcode decoder
package mit_pkg;

    typedef enum logic [3:0] {
        CLS_NOP      = 4'b0000,
        CLS_ARITH    = 4'b0001,
        CLS_LOGIC    = 4'b0010,
        CLS_ACC1     = 4'b0011,
        CLS_XFER     = 4'b0100,
        CLS_XDATA_RD = 4'b0101,
        CLS_XDATA_WR = 4'b0110,
        CLS_CODE_RD  = 4'b0111,
        CLS_BIT      = 4'b1000,
        CLS_BRANCH   = 4'b1001,
        CLS_STACK    = 4'b1010
    } mit_cls_e;

    typedef struct packed {
        logic ready;
        logic retire;
        logic [2:0] left;
        logic [1:0] len;
        logic [2:0] cycles;
        mit_cls_e cls;
        logic xrd;
        logic xwr;
        logic xwide;
        logic code_rd;
        logic code_pc;
        logic bit_valid;
        logic [7:0] bit_byte;
        logic [2:0] bit_pos;
        logic bit_func_reg;
        logic bit_clear;
    } mit_state_s;

endpackage

//--- hdl/mit_op_decode.sv
// opcode decoder: encoded length, cycle count and class for every opcode
`timescale 1ns/1ps
`include "mit_cfg.svh"

module mit_op_decode
    import mit_pkg::*;
(
    input wire logic [7:0] opcode,
    output logic [1:0] len,
    output logic [2:0] cycles,
    output mit_cls_e cls,
    output logic bit_op,
    output logic xdata_wide,
    output logic code_from_pc
);

    function automatic logic [8:0] ent(input logic [1:0] l, input logic [2:0] c,
                                       input mit_cls_e k);
        return {l, c, k};
    endfunction

    logic [8:0] e;

    always_comb
    begin
        e = ent(2'h1, 3'h1, CLS_NOP);
        casez (opcode)
            8'h00: e = ent(2'h1, 3'h1, CLS_NOP);
            8'b???0_0001: e = ent(2'h2, 3'h3, CLS_BRANCH);
            8'b???1_0001: e = ent(2'h2, 3'h4, CLS_BRANCH);
            8'h02: e = ent(2'h3, 3'h4, CLS_BRANCH);
            8'h12: e = ent(2'h3, 3'h4, CLS_BRANCH);
            8'h22, 8'h32: e = ent(2'h1, 3'h4, CLS_BRANCH);
            8'h03, 8'h13, 8'h23, 8'h33: e = ent(2'h1, 3'h1, CLS_ACC1);
            8'h04, 8'h14, 8'hA3: e = ent(2'h1, 3'h1, CLS_ARITH);
            8'h05, 8'h15: e = ent(2'h2, 3'h3, CLS_ARITH);
            8'b000?_011?: e = ent(2'h1, 3'h3, CLS_ARITH);
            8'b000?_1???: e = ent(2'h1, 3'h2, CLS_ARITH);
            `MIT_OPC_BIT_SET_CLEAR, 8'h20, 8'h30: e = ent(2'h3, 3'h5, CLS_BRANCH);
            8'h24, 8'h34, 8'h94, 8'h25, 8'h35, 8'h95: e = ent(2'h2, 3'h2, CLS_ARITH);
            8'b0010_011?, 8'b0011_011?, 8'b1001_011?: e = ent(2'h1, 3'h2, CLS_ARITH);
            8'b0010_1???, 8'b0011_1???, 8'b1001_1???: e = ent(2'h1, 3'h1, CLS_ARITH);
            8'h40, 8'h50: e = ent(2'h2, 3'h3, CLS_BRANCH);
            8'h60, 8'h70: e = ent(2'h2, 3'h4, CLS_BRANCH);
            8'h42, 8'h52, 8'h62: e = ent(2'h2, 3'h3, CLS_LOGIC);
            8'h43, 8'h53, 8'h63: e = ent(2'h3, 3'h3, CLS_LOGIC);
            8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65: e = ent(2'h2, 3'h2, CLS_LOGIC);
            8'b0100_011?, 8'b0101_011?, 8'b0110_011?: e = ent(2'h1, 3'h2, CLS_LOGIC);
            8'b0100_1???, 8'b0101_1???, 8'b0110_1???: e = ent(2'h1, 3'h1, CLS_LOGIC);
            8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2: e = ent(2'h2, 3'h2, CLS_BIT);
            8'h92: e = ent(2'h2, 3'h3, CLS_BIT);
            8'hB2, 8'hC2, 8'hD2: e = ent(2'h2, 3'h3, CLS_BIT);
            8'hB3, 8'hC3, 8'hD3: e = ent(2'h1, 3'h1, CLS_BIT);
            8'h73: e = ent(2'h1, 3'h5, CLS_BRANCH);
            8'h74: e = ent(2'h2, 3'h2, CLS_XFER);
            8'h75, 8'h85: e = ent(2'h3, 3'h3, CLS_XFER);
            8'b0111_011?: e = ent(2'h2, 3'h2, CLS_XFER);
            8'b0111_1???: e = ent(2'h2, 3'h2, CLS_XFER);
            8'h80: e = ent(2'h2, 3'h3, CLS_BRANCH);
            `MIT_OPC_CODE_PC: e = ent(2'h1, 3'h4, CLS_CODE_RD);
            `MIT_OPC_CODE_PTR: e = ent(2'h1, 3'h5, CLS_CODE_RD);
            8'h84: e = ent(2'h1, 3'h6, CLS_ARITH);
            8'hA4: e = ent(2'h1, 3'h2, CLS_ARITH);
            8'hD4: e = ent(2'h1, 3'h3, CLS_ARITH);
            8'b1000_011?: e = ent(2'h2, 3'h3, CLS_XFER);
            8'b1000_1???: e = ent(2'h2, 3'h2, CLS_XFER);
            `MIT_OPC_PTR_LOAD: e = ent(2'h3, 3'h3, CLS_XFER);
            8'b1010_011?: e = ent(2'h2, 3'h3, CLS_XFER);
            8'b1010_1???: e = ent(2'h2, 3'h3, CLS_XFER);
            8'hB4: e = ent(2'h3, 3'h4, CLS_BRANCH);
            `MIT_OPC_CMP_DIR: e = ent(2'h3, 3'h5, CLS_BRANCH);
            8'b1011_011?: e = ent(2'h3, 3'h5, CLS_BRANCH);
            8'b1011_1???: e = ent(2'h3, 3'h4, CLS_BRANCH);
            8'hC0: e = ent(2'h2, 3'h3, CLS_STACK);
            8'hD0: e = ent(2'h2, 3'h2, CLS_STACK);
            8'hC4, 8'hE4, 8'hF4: e = ent(2'h1, 3'h1, CLS_ACC1);
            8'hC5: e = ent(2'h2, 3'h3, CLS_XFER);
            8'b1100_011?, 8'b1101_011?: e = ent(2'h1, 3'h3, CLS_XFER);
            8'b1100_1???: e = ent(2'h1, 3'h2, CLS_XFER);
            8'hD5: e = ent(2'h3, 3'h5, CLS_BRANCH);
            8'b1101_1???: e = ent(2'h2, 3'h4, CLS_BRANCH);
            `MIT_OPC_XRD_WIDE: e = ent(2'h1, 3'h3, CLS_XDATA_RD);
            8'b1110_001?: e = ent(2'h1, 3'h4, CLS_XDATA_RD);
            8'hE5: e = ent(2'h2, 3'h2, CLS_XFER);
            8'b1110_011?: e = ent(2'h1, 3'h2, CLS_XFER);
            8'b1110_1???: e = ent(2'h1, 3'h1, CLS_XFER);
            `MIT_OPC_XWR_WIDE: e = ent(2'h1, 3'h4, CLS_XDATA_WR);
            8'b1111_001?: e = ent(2'h1, 3'h5, CLS_XDATA_WR);
            8'hF5: e = ent(2'h2, 3'h2, CLS_XFER);
            8'b1111_011?: e = ent(2'h1, 3'h2, CLS_XFER);
            8'b1111_1???: e = ent(2'h1, 3'h1, CLS_XFER);
            // the one unused opcode runs as a one-cycle no-op
            default: e = ent(2'h1, 3'h1, CLS_NOP);
        endcase
    end

    always_comb
    begin
        len = e[8:7];
        cycles = e[6:4];
        cls = mit_cls_e'(e[3:0]);
        // direct-bit forms all sit on even opcodes, carry-only forms on odd ones
        bit_op = (e[3:0] == CLS_BIT) && !opcode[0];
        bit_op = bit_op || opcode == `MIT_OPC_BIT_SET_CLEAR || opcode == 8'h20 || opcode == 8'h30;
        xdata_wide = (opcode == `MIT_OPC_XRD_WIDE) || (opcode == `MIT_OPC_XWR_WIDE);
        code_from_pc = (opcode == `MIT_OPC_CODE_PC);
    end

endmodule

//--- testbench/mit_prog_mem.sv
// program memory model: opcode table with length, cycle count and strobe kind
`timescale 1ns/1ps

module mit_prog_mem
#(
    parameter int NUM = 86
)
(
    input wire logic [6:0] idx,
    output logic [7:0] op,
    output logic [3:0] len,
    output logic [3:0] cyc,
    output logic [3:0] kind
);
    // kind: 0 plain, 1/2 ext read 8/16 bit, 3/4 ext write 8/16 bit,
    // 5/6 code read via data pointer/pc, 7 bit op, 8 accumulator op
    logic [19:0] rom [86];

    initial
    begin
        rom = '{
            20'h5_8110, 20'h5_5220, 20'h5_6120, 20'h5_4220, 20'h4_8110, 20'h4_5220,
            20'h4_6120, 20'h4_4220, 20'h6_8110, 20'h6_5220, 20'h6_6120, 20'h6_4220,
            20'h5_2230, 20'h5_3330, 20'h4_2230, 20'h4_3330, 20'h6_2230, 20'h6_3330,
            20'hE_4118, 20'hF_4118, 20'h2_3118, 20'h3_3118, 20'h0_3118, 20'h1_3118,
            20'hC_4118, 20'hE_8110, 20'hE_6120, 20'hE_5220, 20'h7_4220,
            20'hF_8110, 20'hA_8230, 20'h7_8220,
            20'hF_5220, 20'h8_8220, 20'h8_6230, 20'h8_5330, 20'h7_5330,
            20'hF_6120, 20'hA_6230, 20'h7_6220, 20'h9_0330,
            20'h9_3155, 20'h8_3146,
            20'hE_2141, 20'hE_0132, 20'hF_2153, 20'hF_0144,
            20'hC_0230, 20'hD_0220, 20'hC_8120, 20'hC_5230, 20'hC_6130, 20'hD_6130,
            20'hC_3110, 20'hD_3110, 20'hB_3110, 20'hC_2237, 20'hD_2237, 20'hB_2237,
            20'h8_2227, 20'hB_0227, 20'h7_2227, 20'hA_0227, 20'hA_2227, 20'h9_2237,
            20'h4_0230, 20'h5_0230, 20'h2_0357, 20'h3_0357, 20'h1_0357,
            20'h0_1230, 20'h8_0230, 20'h0_2340, 20'h7_3150,
            20'h1_1240, 20'h1_2340, 20'h2_2140, 20'h3_2140,
            20'hB_5350, 20'hB_6350, 20'hB_4340, 20'hB_8340,
            20'hD_8240, 20'hD_5350, 20'h6_0240, 20'h7_0240
        };
    end

    always_comb
    begin
        {op, len, cyc, kind} = rom[int'(idx) % NUM];
    end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the instruction timing unit
`timescale 1ns/1ps

module tb_top
    import mit_pkg::*;
;
    localparam int NUM = 86;
    logic mclk = 1'b0;
    logic sys_rst, op_valid, op_ready, instr_retire;
    logic [7:0] op_byte, op_bit_addr, bit_byte_addr;
    logic [1:0] instr_len;
    logic [2:0] instr_cycles, bit_pos;
    mit_cls_e instr_class;
    logic xdata_rd, xdata_wr, xdata_wide, code_rd, code_base_pc;
    logic bit_valid, bit_in_func_reg, bit_clear;
    logic [6:0] idx;
    logic [3:0] pm_len, pm_cyc, pm_kind;
    int failures, check_count;
    int m_left, m_len, m_cyc, m_kind, m_clsk;
    logic [7:0] m_op, m_addr;
    logic [3:0] m_cls;

    always #2 mclk = ~mclk;

    mit_core_timing DUT (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_byte(op_byte), .op_bit_addr(op_bit_addr), .op_ready(op_ready),
        .instr_retire(instr_retire), .instr_len(instr_len), .instr_cycles(instr_cycles),
        .instr_class(instr_class), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
        .xdata_wide(xdata_wide), .code_rd(code_rd), .code_base_pc(code_base_pc),
        .bit_valid(bit_valid), .bit_byte_addr(bit_byte_addr), .bit_pos(bit_pos),
        .bit_in_func_reg(bit_in_func_reg), .bit_clear(bit_clear));

    mit_prog_mem #(.NUM(NUM)) pmem (.idx(idx), .op(op_byte), .len(pm_len), .cyc(pm_cyc),
        .kind(pm_kind));

    ////////////////////////////////////////////////////////////////////////////////
    // reference model: counts down the listed cycles of each accepted opcode
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            m_left = 0;
            m_len = 0;
            m_cyc = 0;
            m_kind = 0;
            m_cls = CLS_NOP;
            m_clsk = 1;
        end
        else if (op_valid && m_left <= 1)
        begin
            m_left = pm_cyc;
            m_len = pm_len;
            m_cyc = pm_cyc;
            m_kind = pm_kind;
            m_op = op_byte;
            m_addr = op_bit_addr;
            m_clsk = 1;
            case (pm_kind)
                1, 2: m_cls = CLS_XDATA_RD;
                3, 4: m_cls = CLS_XDATA_WR;
                5, 6: m_cls = CLS_CODE_RD;
                8: m_cls = CLS_ACC1;
                // class of plain ops is the designer's grouping, not checked
                default: m_clsk = 0;
            endcase
        end
        else if (m_left > 0)
            m_left = m_left - 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic compare();
        logic act;
        logic [7:0] ba;
        act = m_left > 0;
        ba = m_addr[7] ? {m_addr[7:3], 3'h0} : 8'h20 + 8'(m_addr[6:3]);
        check(8'(op_ready), 8'(m_left <= 1), "ready");
        check(8'(instr_retire), 8'(m_left == 1), "retire");
        check(8'(instr_len), 8'(m_len), "length");
        check(8'(instr_cycles), 8'(m_cyc), "cycles");
        if (m_clsk == 1)
            check(8'(instr_class), 8'(m_cls), "class");
        check(8'(xdata_rd), 8'(act && (m_kind == 1 || m_kind == 2)), "ext read");
        check(8'(xdata_wr), 8'(act && (m_kind == 3 || m_kind == 4)), "ext write");
        check(8'(code_rd), 8'(act && (m_kind == 5 || m_kind == 6)), "code read");
        check(8'(bit_valid), 8'(act && m_kind == 7), "bit op");
        if (act && m_kind >= 1 && m_kind <= 4)
            check(8'(xdata_wide), 8'(m_kind == 2 || m_kind == 4), "wide");
        if (act && (m_kind == 5 || m_kind == 6))
            check(8'(code_base_pc), 8'(m_kind == 6), "code base");
        if (act && m_kind == 7)
        begin
            check(bit_byte_addr, ba, "bit byte");
            check(8'(bit_pos), 8'(m_addr[2:0]), "bit pos");
            check(8'(bit_in_func_reg), 8'(m_addr[7]), "bit register space");
            check(8'(bit_clear), 8'(m_op == 8'h10), "bit clear");
        end
    endtask

    // offer one opcode and keep it up while refused
    task automatic offer(input int k, input logic [7:0] a);
        int n;
        n = 0;
        op_valid = 1'b1;
        idx = 7'(k);
        op_bit_addr = a;
        while (m_left > 1 && n < 20)
        begin
            @(negedge mclk);
            compare();
            n++;
        end
        @(negedge mclk);
        compare();
        check(8'(n < 20), 8'h01, "opcode refused too long");
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        check_count = 0;
        sys_rst = 1'b1;
        op_valid = 1'b0;
        idx = 7'h00;
        op_bit_addr = 8'h00;
        void'($urandom(40));
        repeat (10) @(negedge mclk);
        compare();
        sys_rst = 1'b0;
        // every table opcode back to back, bit addresses spread over ram and register space
        for (int i = 0; i < NUM; i++)
            offer(i, 8'(i * 3));
        // random traffic with a reset in mid-run
        for (int j = 0; j < 2000; j++)
        begin
            sys_rst = (j >= 1000 && j < 1003);
            op_valid = (($urandom % 4) != 0);
            idx = 7'($urandom % NUM);
            op_bit_addr = 8'($urandom);
            @(negedge mclk);
            compare();
        end
        end_sim();
    end

    // run needs about 2250 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
